// ==== rtl/dspcr_params.svh ====
// Field positions, write masks, reset values and selector codes for the DSP control registers.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef DSPCR_PARAMS_SVH
`define DSPCR_PARAMS_SVH

// Control register selectors on the decode port
`define DSPCR_SEL_STATUS 3'h0
`define DSPCR_SEL_LOOP_BEGIN 3'h1
`define DSPCR_SEL_LOOP_FINISH 3'h2
`define DSPCR_SEL_WRAP 3'h3
`define DSPCR_SEL_SAVED 3'h4
`define DSPCR_SEL_DSP_FLAGS 3'h5

// Status word field positions
`define DSPCR_SW_SUP_BIT 30
`define DSPCR_SW_BANK_BIT 29
`define DSPCR_SW_GATE_BIT 28
`define DSPCR_SW_CNT_HI 27
`define DSPCR_SW_CNT_LO 16
`define DSPCR_SW_DSPEN_BIT 12
`define DSPCR_SW_YWRAP_BIT 11
`define DSPCR_SW_XWRAP_BIT 10
`define DSPCR_SW_MASK_HI 7
`define DSPCR_SW_MASK_LO 4
`define DSPCR_SW_LFLAG_HI 3
`define DSPCR_SW_LFLAG_LO 2

// Fields writable from user DSP mode: counter, loop flags, wrap enables
`define DSPCR_SW_USER_WMASK 32'h0fff0c0c

// Status word reset: supervisor, bank, gate set, mask 1111, rest clear
`define DSPCR_SW_RESET 32'h700000f0
`define DSPCR_FINISH_RESET 32'h00000000

// Wrap bounds halves
`define DSPCR_WRAP_UPPER_LO 16
`define DSPCR_WRAP_LOWER_HI 15

// Accumulator guard width and DSP flag positions
`define DSPCR_GUARD_W 8
`define DSPCR_DF_COND_BIT 0
`define DSPCR_DF_NEG_BIT 1
`define DSPCR_DF_ZERO_BIT 2
`define DSPCR_DF_OVF_BIT 3

`endif

// ==== rtl/dspcr_pkg.sv ====
// Types shared by the DSP control register block.
// Assumes dspcr_params.svh is on the include path.
package dspcr_pkg;

	typedef enum logic [1:0]
	{
		DSPCR_MODE_USER = 2'b00,
		DSPCR_MODE_USER_DSP = 2'b01,
		DSPCR_MODE_PRIV = 2'b10,
		DSPCR_MODE_PRIV_DSP = 2'b11
	} dspcr_mode_t;

	// Control access request from decode
	typedef struct packed
	{
		logic valid;
		logic is_load;
		logic [2:0] sel;
		logic [31:0] wdata;
	} dspcr_req_t;

	// Answer to decode
	typedef struct packed
	{
		logic done;
		logic illegal;
		logic [31:0] rdata;
	} dspcr_rsp_t;

	// Result of one DSP data operation
	typedef struct packed
	{
		logic valid;
		logic [2:0] dst;
		logic [39:0] value;
		logic carry;
		logic overflow;
		logic cond;
	} dspcr_dres_t;

endpackage

// ==== rtl/dspcr_access_check.sv ====
// Privilege check for control register load and store.
// Assumes mode derived from live status word; purely combinational.
`timescale 1ns/10ps
`include "dspcr_params.svh"

module dspcr_access_check
	import dspcr_pkg::*;
(
	input wire dspcr_mode_t mode_i,
	input wire logic [2:0] sel_i,
	input wire logic is_load_i,
	output logic allowed_o,
	output logic [31:0] wmask_o
);

	// Permission and per-field write mask
	always_comb
	begin
		allowed_o = 1'b0;
		wmask_o = 32'h00000000;
		case (sel_i)
			`DSPCR_SEL_LOOP_BEGIN, `DSPCR_SEL_LOOP_FINISH, `DSPCR_SEL_WRAP:
			begin
				allowed_o = (mode_i == DSPCR_MODE_PRIV_DSP) || (mode_i == DSPCR_MODE_USER_DSP);
				wmask_o = 32'hffffffff;
			end
			`DSPCR_SEL_STATUS:
			begin
				allowed_o = mode_i != DSPCR_MODE_USER;
				wmask_o = (mode_i == DSPCR_MODE_USER_DSP) ? `DSPCR_SW_USER_WMASK : 32'hffffffff;
			end
			`DSPCR_SEL_SAVED, `DSPCR_SEL_DSP_FLAGS:
			begin
				allowed_o = (mode_i == DSPCR_MODE_PRIV) || (mode_i == DSPCR_MODE_PRIV_DSP);
				wmask_o = is_load_i ? 32'hffffffff : 32'h00000000;
			end
			default:
			begin
				allowed_o = 1'b0;
				wmask_o = 32'h00000000;
			end
		endcase
	end

endmodule

// ==== rtl/dspcr_regs.sv ====
// DSP extension control registers, status word, saved status and DSP data registers.
// Assumes decode presents one control access per cycle and pulses exception entry.
`timescale 1ns/10ps
`include "dspcr_params.svh"

// What this block does
// - A loop-begin pointer exists, only reachable in DSP modes, unset by reset and kept over exceptions.
// - A loop-finish pointer exists, only reachable in DSP modes, zero after reset and kept over exceptions.
// - The wrap-bounds register holds the upper wrap address high and the lower one low, kept over exceptions.
// - Control loads and stores of the three loop and wrap registers run only in the two DSP modes.
// - Touching the loop-begin pointer from plain user mode raises an illegal-instruction exception.
// - Status word access runs only with supervisor set or in user DSP mode, else it is illegal.
// - Supervisor flag and DSP enable together select one of four modes that steer field access.
// - In both privileged modes a status load writes every field and a store returns every field.
// - In user DSP mode a status store returns the whole word.
// - In user DSP mode a status load changes only counter, loop flags and wrap enables.
// - Reset sets supervisor, bank and gate, clears enable, wraps and counter, and sets the mask to 1111.
// - Exception entry copies the whole status word into the saved status word.
// - Eight 32-bit data registers exist, the two accumulators widened by 8 guard bits to 40.
// - A DSP flags register records zero, negative and other results plus a condition flag.
// - The 12-bit loop counter sits in status bits 27 to 16, writable outside plain user mode.
// - The DSP enable sits at status bit 12 and cannot change from user DSP mode.
module dspcr_regs
	import dspcr_pkg::*;
#(
	parameter int DATA_REGS = 8,
	parameter int ACC_W = 40
)
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire dspcr_req_t req_i,
	input wire logic exc_entry_i,
	input wire logic [31:0] exc_status_i,
	input wire logic exc_status_we_i,
	input wire dspcr_dres_t dres_i,
	input wire logic [2:0] dread_sel_i,
	output dspcr_rsp_t rsp_o,
	output dspcr_mode_t mode_o,
	output logic [31:0] status_o,
	output logic [31:0] loop_begin_o,
	output logic [31:0] loop_finish_o,
	output logic [15:0] wrap_upper_o,
	output logic [15:0] wrap_lower_o,
	output logic [39:0] dread_o,
	output logic [31:0] dsp_flags_o
);

	// Guard against shapes the flag and selector logic cannot serve
	if (DATA_REGS != 8 || ACC_W != 32 + `DSPCR_GUARD_W)
	begin
		$error("dspcr_regs: unsupported register set shape");
	end

	logic [31:0] status_r, status_nxt;
	logic [31:0] saved_r, saved_nxt;
	logic [31:0] loop_begin_r, loop_begin_nxt;
	logic [31:0] loop_finish_r, loop_finish_nxt;
	logic [31:0] wrap_r, wrap_nxt;
	logic [31:0] dflags_r, dflags_nxt;
	logic [39:0] data_r [DATA_REGS];
	logic [39:0] data_nxt [DATA_REGS];
	dspcr_rsp_t rsp_r, rsp_nxt;
	logic allowed;
	logic [31:0] wmask;
	logic do_load;
	logic do_store;

	// mode from supervisor flag and DSP enable
	assign mode_o = dspcr_mode_t'({status_r[`DSPCR_SW_SUP_BIT], status_r[`DSPCR_SW_DSPEN_BIT]});

	dspcr_access_check u_check
	(
		.mode_i(mode_o),
		.sel_i(req_i.sel),
		.is_load_i(req_i.is_load),
		.allowed_o(allowed),
		.wmask_o(wmask)
	);

	assign do_load = req_i.valid && allowed && req_i.is_load;
	assign do_store = req_i.valid && allowed && !req_i.is_load;

	// Control register next state
	always_comb
	begin
		status_nxt = status_r;
		saved_nxt = saved_r;
		loop_begin_nxt = loop_begin_r;
		loop_finish_nxt = loop_finish_r;
		wrap_nxt = wrap_r;
		// whole word saved on exception entry
		if (exc_entry_i)
			saved_nxt = status_r;
		else if (exc_status_we_i)
			saved_nxt = exc_status_i; // Return path restores from handler copy
		if (do_load)
		begin
			case (req_i.sel)
				`DSPCR_SEL_STATUS:
				begin
					status_nxt = (status_r & ~wmask) | (req_i.wdata & wmask);
				end
				`DSPCR_SEL_LOOP_BEGIN: loop_begin_nxt = req_i.wdata;
				`DSPCR_SEL_LOOP_FINISH: loop_finish_nxt = req_i.wdata;
				`DSPCR_SEL_WRAP: wrap_nxt = req_i.wdata;
				`DSPCR_SEL_SAVED:
				begin
					if (!exc_entry_i)
						saved_nxt = req_i.wdata;
				end
				default: saved_nxt = saved_nxt;
			endcase
		end
		// Exception entry leaves pointers, wraps and live status alone
	end

	// Answer to decode, registered one cycle after the request
	always_comb
	begin
		rsp_nxt.done = req_i.valid && allowed;
		rsp_nxt.illegal = req_i.valid && !allowed;
		rsp_nxt.rdata = 32'h00000000;
		if (do_store)
		begin
			case (req_i.sel)
				`DSPCR_SEL_STATUS: rsp_nxt.rdata = status_r;
				`DSPCR_SEL_LOOP_BEGIN: rsp_nxt.rdata = loop_begin_r;
				`DSPCR_SEL_LOOP_FINISH: rsp_nxt.rdata = loop_finish_r;
				`DSPCR_SEL_WRAP: rsp_nxt.rdata = wrap_r;
				`DSPCR_SEL_SAVED: rsp_nxt.rdata = saved_r;
				`DSPCR_SEL_DSP_FLAGS: rsp_nxt.rdata = dflags_r;
				default: rsp_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	// Result shaping: accumulators keep all 40 bits, the rest only 32
	logic res_to_acc;
	logic [39:0] res_value;
	logic res_zero;
	logic res_neg;
	logic flags_load;
	logic [39:0] dread_r, dread_nxt;

	// accumulators keep guard bits, others 32 bits
	always_comb
	begin
		res_to_acc = dres_i.dst < 3'h2;
		if (res_to_acc)
			res_value = dres_i.value;
		else
			res_value = {8'h00, dres_i.value[31:0]}; // Upper guard byte forced clear
	end

	// zero and sign judged on the width actually stored
	always_comb
	begin
		if (res_to_acc)
		begin
			res_zero = dres_i.value == 40'h0000000000;
			res_neg = dres_i.value[39];
		end
		else
		begin
			res_zero = dres_i.value[31:0] == 32'h00000000;
			res_neg = dres_i.value[31];
		end
	end

	// Software flag load, lower priority than a result
	assign flags_load = do_load && (req_i.sel == `DSPCR_SEL_DSP_FLAGS);

	// Data register next state
	always_comb
	begin
		for (int i = 0; i < DATA_REGS; i++)
			data_nxt[i] = data_r[i];
		// write lands in the selected register
		if (dres_i.valid)
			data_nxt[dres_i.dst] = res_value;
	end

	// Data registers: no reset, so software writes before it reads
	always_ff @(posedge clk_i)
	begin
		for (int i = 0; i < DATA_REGS; i++)
			data_r[i] <= data_nxt[i];
	end

	// DSP flags next state
	always_comb
	begin
		dflags_nxt = dflags_r;
		if (dres_i.valid)
		begin
			dflags_nxt[`DSPCR_DF_ZERO_BIT] = res_zero;
			dflags_nxt[`DSPCR_DF_NEG_BIT] = res_neg;
			dflags_nxt[`DSPCR_DF_OVF_BIT] = dres_i.overflow;
			dflags_nxt[`DSPCR_DF_COND_BIT] = dres_i.cond;
		end
		// Software load wins only where no result arrives this cycle
		else if (flags_load)
			dflags_nxt = req_i.wdata;
	end

	// DSP flags register
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			dflags_r <= 32'h00000000;
		else
			dflags_r <= dflags_nxt;
	end

	// Loop-begin pointer and wrap register: no reset, contents undefined at start
	always_ff @(posedge clk_i)
	begin
		loop_begin_r <= loop_begin_nxt;
		wrap_r <= wrap_nxt;
	end

	// Saved status: no reset, only meaningful once an exception was taken
	always_ff @(posedge clk_i)
	begin
		// copy chosen in the next-state logic
		saved_r <= saved_nxt;
	end

	// Status word, defined from reset
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			status_r <= `DSPCR_SW_RESET;
		end
		else
			status_r <= status_nxt;
	end

	// Loop-finish pointer, defined from reset
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			loop_finish_r <= `DSPCR_FINISH_RESET;
		end
		else
			loop_finish_r <= loop_finish_nxt;
	end

	// Answer register: each request gives a one-cycle pulse
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		// Done and illegal never rise together
		if (!resetn_i)
			rsp_r <= '0;
		else
			rsp_r <= rsp_nxt;
	end

	// Register contents straight to the ports
	assign rsp_o = rsp_r;
	assign status_o = status_r;
	assign loop_begin_o = loop_begin_r;
	assign loop_finish_o = loop_finish_r;
	assign wrap_upper_o = wrap_r[31:`DSPCR_WRAP_UPPER_LO];
	assign wrap_lower_o = wrap_r[`DSPCR_WRAP_LOWER_HI:0];
	assign dsp_flags_o = dflags_r;
	assign dread_o = dread_r;

	// Data read port next value; eight registers cover every select code
	always_comb
	begin
		dread_nxt = data_r[dread_sel_i];
	end

	// Data read port, registered so the value stands a full cycle
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			dread_r <= 40'h0000000000;
		else
			dread_r <= dread_nxt;
	end

endmodule

// ==== tb/dspcr_cpu_model.sv ====
// Exception side of the CPU: enters handling after a refused access.
// Assumes the register block's clock and answer port.
`timescale 1ns/10ps
module dspcr_cpu_model
	import dspcr_pkg::*;
(
	input wire logic clk_i,
	input wire dspcr_rsp_t rsp_i,
	output logic exc_entry_o
);
	// Entry pulse half a cycle after the refusal, clear of the sampling edge
	initial exc_entry_o = 1'b0;
	always @(negedge clk_i)
	begin
		exc_entry_o <= rsp_i.illegal;
	end
endmodule

// ==== tb/dspcr_regs_properties.sv ====
// Timing and access checks on the control register ports.
// Assumes one clock domain and the async low reset.
`timescale 1ns/10ps
module dspcr_regs_properties
	import dspcr_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire dspcr_req_t req_i,
	input wire dspcr_rsp_t rsp_o,
	input wire dspcr_mode_t mode_o,
	input wire logic [31:0] status_o,
	input wire logic [31:0] loop_finish_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_answer_once: assert property (req_i.valid |=> rsp_o.done ^ rsp_o.illegal)
		else $error("no single answer");
	a_idle_quiet: assert property (!req_i.valid |=> !(rsp_o.done || rsp_o.illegal))
		else $error("answer without request");
	a_user_status: assert property (req_i.valid && req_i.sel == 3'h0 && mode_o == DSPCR_MODE_USER
		|=> rsp_o.illegal)
		else $error("status access not refused");
	a_loop_dsp_only: assert property (req_i.valid && req_i.sel inside {[1:3]} && !status_o[12]
		|=> rsp_o.illegal && rsp_o.rdata == 32'h0)
		else $error("loop register reachable outside dsp");
	a_user_load_mask: assert property (req_i.valid && req_i.is_load && req_i.sel == 3'h0
		&& mode_o == DSPCR_MODE_USER_DSP |=> status_o == (($past(status_o) & 32'hf000f3f3)
		| ($past(req_i.wdata) & 32'h0fff0c0c)))
		else $error("user dsp load mask wrong");
	a_priv_load_all: assert property (req_i.valid && req_i.is_load && req_i.sel == 3'h0 && status_o[30]
		|=> (status_o & 32'h7fff1cfc) == ($past(req_i.wdata) & 32'h7fff1cfc))
		else $error("privileged load incomplete");
	a_reset_value: assert property ($rose(resetn_i) |-> status_o == 32'h700000f0
		&& loop_finish_o == 32'h0)
		else $error("reset contents wrong");
	a_finish_hold: assert property (!(req_i.valid && req_i.is_load && req_i.sel == 3'h2)
		|=> $stable(loop_finish_o))
		else $error("loop finish changed");
	a_mode_map: assert property (mode_o == {status_o[30], status_o[12]})
		else $error("mode not from status");
endmodule
bind dspcr_regs dspcr_regs_properties u_props (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
	.rsp_o(rsp_o), .mode_o(mode_o), .status_o(status_o), .loop_finish_o(loop_finish_o));

// ==== tb/tb_dsp_control_register_access.sv ====
// Self-checking bench for the DSP control registers.
// Assumes the cpu model turns each refusal into exception entry.
`timescale 1ns/10ps
module tb_dsp_control_register_access
	import dspcr_pkg::*;
;
	localparam logic [31:0] UM = 32'h0fff0c0c;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	dspcr_req_t req_i = '0;
	dspcr_dres_t dres_i = '0;
	logic [2:0] dread_sel_i = 3'h0;
	logic exc_entry_i;
	dspcr_rsp_t rsp_o;
	dspcr_mode_t mode_o;
	logic [31:0] status_o, loop_begin_o, loop_finish_o, dsp_flags_o, sw, sv, w;
	logic [31:0] rv[1:3];
	logic [15:0] wrap_upper_o, wrap_lower_o;
	logic [39:0] dread_o, d;
	logic [33:0] expq[$];
	logic [33:0] e;
	integer seed = 32'had75;
	int fail_count = 0;
	int checked = 0;
	dspcr_regs u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .exc_entry_i(exc_entry_i),
		.exc_status_i(32'h0), .exc_status_we_i(1'b0), .dres_i(dres_i), .dread_sel_i(dread_sel_i),
		.rsp_o(rsp_o), .mode_o(mode_o), .status_o(status_o), .loop_begin_o(loop_begin_o),
		.loop_finish_o(loop_finish_o), .wrap_upper_o(wrap_upper_o), .wrap_lower_o(wrap_lower_o),
		.dread_o(dread_o), .dsp_flags_o(dsp_flags_o));
	dspcr_cpu_model u_cpu (.clk_i(clk_i), .rsp_i(rsp_o), .exc_entry_o(exc_entry_i));
	initial forever #12.5 clk_i = ~clk_i;
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One access per falling edge, so back to back is the default
	task automatic acc(input logic ld, input logic [2:0] s, input logic [31:0] wd, input logic ill,
		input logic ck, input logic [31:0] rd);
		@(negedge clk_i);
		req_i <= '{1'b1, ld, s, wd};
		expq.push_back({ill, ck, rd});
		if (ill)
			sv = sw;
	endtask
	task automatic idle();
		@(negedge clk_i);
		req_i.valid <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Oldest note against each answer; late sample lets the edge settle
	always @(posedge clk_i)
	begin
		#1;
		if (rsp_o.done === 1'b1 || rsp_o.illegal === 1'b1)
		begin
			e = expq.pop_front();
			chk(rsp_o.illegal, e[33]);
			if (e[32])
				chk(rsp_o.rdata, e[31:0]);
		end
	end
	// Hang guard
	initial
	begin
		#100000;
		fail_count++;
		end_of_test();
	end
	initial
	begin
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		resetn_i = 1'b1;
		sw = 32'h700000f0;
		chk(status_o, sw);
		chk(loop_finish_o, 32'h0);
		chk(mode_o, DSPCR_MODE_PRIV);
		// loop registers and spare selectors refused when privileged without DSP enable
		for (int s = 1; s < 8; s++)
			acc(1'b0, 3'(s), 32'h0, s != 4 && s != 5, 1'b1, (s == 4) ? sv : 32'h0);
		w = ($random(seed) & 32'h0fff0cfc) | 32'h70001000;
		acc(1'b1, 3'h0, w, 1'b0, 1'b0, 32'h0);
		sw = w;
		acc(1'b0, 3'h0, 32'h0, 1'b0, 1'b1, sw);
		// write then read each loop register back to back
		for (int s = 1; s < 4; s++)
		begin
			rv[s] = $random(seed);
			acc(1'b1, 3'(s), rv[s], 1'b0, 1'b0, 32'h0);
			acc(1'b0, 3'(s), 32'h0, 1'b0, 1'b1, rv[s]);
		end
		idle();
		chk({wrap_upper_o, wrap_lower_o}, rv[3]);
		chk(loop_begin_o, rv[1]);
		chk(mode_o, DSPCR_MODE_PRIV_DSP);
		// user DSP loads touch only their own fields
		acc(1'b1, 3'h0, (sw & UM) | 32'h30001000, 1'b0, 1'b0, 32'h0);
		sw = (sw & UM) | 32'h30001000;
		repeat (6)
		begin
			w = $random(seed);
			acc(1'b1, 3'h0, w, 1'b0, 1'b0, 32'h0);
			sw = (sw & ~UM) | (w & UM);
		end
		acc(1'b0, 3'h0, 32'h0, 1'b0, 1'b1, sw);
		acc(1'b0, 3'h4, 32'h0, 1'b1, 1'b1, 32'h0);
		for (int s = 1; s < 4; s++)
			acc(1'b0, 3'(s), 32'h0, 1'b0, 1'b1, rv[s]);
		idle();
		chk(status_o, sw);
		chk(mode_o, DSPCR_MODE_USER_DSP);
		// saved copy read back after a second reset
		resetn_i = 1'b0;
		repeat (2) @(negedge clk_i);
		resetn_i = 1'b1;
		sw = 32'h700000f0;
		acc(1'b0, 3'h4, 32'h0, 1'b0, 1'b1, sv);
		// handler refills the loop-finish pointer that reset cleared
		acc(1'b1, 3'h0, 32'h70001000, 1'b0, 1'b0, 32'h0);
		acc(1'b0, 3'h2, 32'h0, 1'b0, 1'b1, 32'h0);
		acc(1'b1, 3'h2, rv[2], 1'b0, 1'b0, 32'h0);
		acc(1'b0, 3'h2, 32'h0, 1'b0, 1'b1, rv[2]);
		acc(1'b1, 3'h0, 32'h700000f0, 1'b0, 1'b0, 32'h0);
		// plain user mode refuses status and loop begin
		acc(1'b1, 3'h0, 32'h300000f0, 1'b0, 1'b0, 32'h0);
		sw = 32'h300000f0;
		acc(1'b1, 3'h0, 32'h70001000, 1'b1, 1'b1, 32'h0);
		acc(1'b0, 3'h1, 32'h0, 1'b1, 1'b1, 32'h0);
		idle();
		chk(status_o, sw);
		chk(mode_o, DSPCR_MODE_USER);
		// accumulator keeps guard bits, plain register drops them
		w = $random(seed);
		d = {w[7:0], 32'($random(seed))};
		dres_i <= '{1'b1, 3'h0, d, 1'b0, 1'b0, 1'b0};
		@(negedge clk_i);
		dres_i <= '{1'b1, 3'h2, d, 1'b0, 1'b0, 1'b1};
		@(negedge clk_i);
		dres_i.valid <= 1'b0;
		dread_sel_i <= 3'h2;
		chk(dread_o, d);
		chk(dsp_flags_o[0], 1'b1);
		chk(dsp_flags_o[2:1], {d[31:0] == 32'h0, d[31]});
		@(negedge clk_i);
		chk(dread_o, {8'h0, d[31:0]});
		chk(expq.size(), 0);
		end_of_test();
	end
endmodule
